// *** core/mpw_core.v ***
/*
 * Memory page windowing core: turns CPU and debug accesses into 23-bit
 * global addresses through RAM and EEPROM windows, a global page, a
 * movable direct page and a debug page, and runs them on a
 * non-multiplexed external bus with separate read and write strobes.
 * Assumes one clock, requesters that hold a request until acknowledged,
 * and an Avalon-MM master on the register port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpw_defines.vh"

module mpw_core #(
    parameter ADDR_W = 23,
    parameter DATA_W = 16
) (
    input wire mclk_i,
    input wire arst_n_i,
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    input wire cpu_req_i,
    input wire cpu_we_i,
    input wire cpu_global_i,
    input wire cpu_direct_i,
    input wire [15:0] cpu_addr_i,
    input wire [DATA_W-1:0] cpu_wdata_i,
    output reg cpu_ack_o,
    output reg [DATA_W-1:0] cpu_rdata_o,
    input wire dbg_req_i,
    input wire dbg_we_i,
    input wire [15:0] dbg_addr_i,
    input wire [DATA_W-1:0] dbg_wdata_i,
    input wire dbg_page_wr_i,
    input wire [7:0] dbg_page_i,
    output reg dbg_ack_o,
    output reg [DATA_W-1:0] dbg_rdata_o,
    output reg [ADDR_W-1:0] ext_addr_o,
    output reg [DATA_W-1:0] ext_data_o,
    output reg ext_data_oe_o,
    input wire [DATA_W-1:0] ext_data_i,
    output reg read_strobe_o,
    output reg write_strobe_o
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_STROBE = 3'b010;
    localparam [2:0] ST_ACK = 3'b100;

    reg [2:0] ram_window_select_reg;
    reg [1:0] eeprom_window_select_reg;
    reg [6:0] global_block_select_reg;
    reg [7:0] dp_base_reg;
    reg [7:0] dbg_page_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [1:0] strobe_cnt_reg;
    reg owner_dbg_reg;
    reg we_reg;
    reg [ADDR_W-1:0] last_addr_reg;
    reg [31:0] rd_mux;
    reg [15:0] cpu_local;
    reg [ADDR_W-1:0] cpu_gaddr;
    reg [ADDR_W-1:0] dbg_gaddr;
    wire [5:0] reg_idx;
    wire bus_req;
    wire bus_commit;

    // Local 16-bit address to global address through the windows. The
    // selects are passed in so this stays a pure function of its inputs.
    function [ADDR_W-1:0] map_local;
        input [15:0] la;
        input [2:0] ram_sel;
        input [1:0] ee_sel;
        begin
            if (la[15:11] == `MPW_LOC_REG_HI) begin
                map_local = {`MPW_REG_PAGE, la};
            end else if (la[15:10] == `MPW_LOC_EE_WIN) begin
                map_local = {`MPW_EE_BASE_HI, ee_sel, la[9:0]};
            end else if (la[15:10] == `MPW_LOC_EE_FIX) begin
                map_local = {`MPW_EE_BASE_HI, `MPW_EE_FIXED, la[9:0]};
            end else if (la[15:12] == `MPW_LOC_RAM_WIN) begin
                map_local = {`MPW_RAM_BASE_HI, ram_sel, la[11:0]};
            end else if (la[15:13] == `MPW_LOC_RAM_FIX) begin
                map_local = {`MPW_RAM_BASE_HI, `MPW_RAM_FIXED_HI, la[12:0]};
            end else begin
                map_local = {`MPW_FAR_PAGE, la};
            end
        end
    endfunction

    always @* begin
        if (cpu_direct_i) begin
            cpu_local = {dp_base_reg, cpu_addr_i[7:0]};
        end else begin
            cpu_local = cpu_addr_i;
        end
        if (cpu_global_i) begin
            cpu_gaddr = {global_block_select_reg, cpu_addr_i};
        end else begin
            cpu_gaddr = map_local(cpu_local, ram_window_select_reg,
                eeprom_window_select_reg);
        end
    end

    // Debug accesses use the debug page while its enable bit is set; user selects are only read
    // when the debug page is off, so the CPU view is what debug then sees.
    always @* begin
        if (dbg_page_reg[`MPW_DBG_EN_BIT]) begin
            dbg_gaddr = {dbg_page_reg[`MPW_DBG_PAGE_MSB:0], dbg_addr_i};
        end else begin
            dbg_gaddr = map_local(dbg_addr_i, ram_window_select_reg,
                eeprom_window_select_reg);
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (dbg_req_i || cpu_req_i) begin
                    state_next = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (strobe_cnt_reg == 2'h1) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // External bus sequencer. Debug wins over the CPU so a halted or busy
    // CPU cannot starve the debug port; the CPU simply waits one access.
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
            strobe_cnt_reg <= 2'h0;
            owner_dbg_reg <= 1'b0;
            we_reg <= 1'b0;
            last_addr_reg <= {ADDR_W{1'b0}};
            ext_addr_o <= {ADDR_W{1'b0}};
            ext_data_o <= {DATA_W{1'b0}};
            ext_data_oe_o <= 1'b0;
            read_strobe_o <= 1'b0;
            write_strobe_o <= 1'b0;
            cpu_ack_o <= 1'b0;
            dbg_ack_o <= 1'b0;
            cpu_rdata_o <= {DATA_W{1'b0}};
            dbg_rdata_o <= {DATA_W{1'b0}};
        end else begin
            state_reg <= state_next;
            cpu_ack_o <= 1'b0;
            dbg_ack_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (dbg_req_i) begin
                        owner_dbg_reg <= 1'b1;
                        we_reg <= dbg_we_i;
                        ext_addr_o <= dbg_gaddr;
                        last_addr_reg <= dbg_gaddr;
                        ext_data_o <= dbg_wdata_i;
                        ext_data_oe_o <= dbg_we_i;
                        read_strobe_o <= ~dbg_we_i;
                        write_strobe_o <= dbg_we_i;
                        strobe_cnt_reg <= `MPW_STROBE_CYCLES;
                    end else if (cpu_req_i) begin
                        owner_dbg_reg <= 1'b0;
                        we_reg <= cpu_we_i;
                        ext_addr_o <= cpu_gaddr;
                        last_addr_reg <= cpu_gaddr;
                        ext_data_o <= cpu_wdata_i;
                        ext_data_oe_o <= cpu_we_i;
                        read_strobe_o <= ~cpu_we_i;
                        write_strobe_o <= cpu_we_i;
                        strobe_cnt_reg <= `MPW_STROBE_CYCLES;
                    end
                end
                ST_STROBE: begin
                    strobe_cnt_reg <= strobe_cnt_reg - 2'h1;
                    if (strobe_cnt_reg == 2'h1) begin
                        read_strobe_o <= 1'b0;
                        write_strobe_o <= 1'b0;
                        ext_data_oe_o <= 1'b0;
                        cpu_ack_o <= ~owner_dbg_reg;
                        dbg_ack_o <= owner_dbg_reg;
                        if (!we_reg && owner_dbg_reg) begin
                            dbg_rdata_o <= ext_data_i;
                        end
                        if (!we_reg && !owner_dbg_reg) begin
                            cpu_rdata_o <= ext_data_i;
                        end
                    end
                end
                ST_ACK: begin
                    strobe_cnt_reg <= 2'h0;
                end
                default: begin
                    strobe_cnt_reg <= 2'h0;
                end
            endcase
        end
    end

    // The debug page has its own write path from the debug port, so a
    // debug tool never needs to touch the user window selects.
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dbg_page_reg <= `MPW_RST_DBG_PAGE;
        end else if (dbg_page_wr_i) begin
            dbg_page_reg <= dbg_page_i;
        end
    end

    assign reg_idx = avs_address_i[7:2];
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_commit = bus_req & ~avs_waitrequest_o;

    always @* begin
        rd_mux = 32'h00000000;
        case (reg_idx)
            `MPW_OFS_RAM_SEL: rd_mux[2:0] = ram_window_select_reg;
            `MPW_OFS_EE_SEL: rd_mux[1:0] = eeprom_window_select_reg;
            `MPW_OFS_GBL_SEL: rd_mux[6:0] = global_block_select_reg;
            `MPW_OFS_DP_BASE: rd_mux[7:0] = dp_base_reg;
            `MPW_OFS_DBG_PAGE: rd_mux[7:0] = dbg_page_reg;
            `MPW_OFS_STATUS: begin
                rd_mux[ADDR_W-1:0] = last_addr_reg;
                rd_mux[24] = ~state_reg[0];
                rd_mux[25] = owner_dbg_reg;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Every access answers after one wait cycle: waitrequest drops on the
    // edge after the request appears and the write lands on the next edge.
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
            ram_window_select_reg <= `MPW_RST_RAM_SEL;
            eeprom_window_select_reg <= `MPW_RST_EE_SEL;
            global_block_select_reg <= `MPW_RST_GBL_SEL;
            dp_base_reg <= `MPW_RST_DP_BASE;
        end else begin
            if (bus_commit) begin
                avs_waitrequest_o <= 1'b1;
            end else if (bus_req) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= rd_mux;
            end
            if (bus_commit && avs_write_i && avs_byteenable_i[0]) begin
                case (reg_idx)
                    `MPW_OFS_RAM_SEL: begin
                        ram_window_select_reg <= avs_writedata_i[2:0];
                    end
                    `MPW_OFS_EE_SEL: begin
                        eeprom_window_select_reg <= avs_writedata_i[1:0];
                    end
                    `MPW_OFS_GBL_SEL: begin
                        global_block_select_reg <= avs_writedata_i[6:0];
                    end
                    `MPW_OFS_DP_BASE: begin
                        dp_base_reg <= avs_writedata_i[7:0];
                    end
                    default: begin
                        dp_base_reg <= dp_base_reg;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// *** core/mpw_defines.vh ***
/*
 * Constants of the memory page windowing block: register offsets, reset
 * values, window bases in the 23-bit global space and field positions.
 * Assumes inclusion by bare name from the windowing core only.
 */
`ifndef MPW_DEFINES_VH
`define MPW_DEFINES_VH

// Register word indexes on the Avalon-MM slave (byte address bits 7:2).
`define MPW_OFS_RAM_SEL 6'h00
`define MPW_OFS_EE_SEL 6'h01
`define MPW_OFS_GBL_SEL 6'h02
`define MPW_OFS_DP_BASE 6'h03
`define MPW_OFS_DBG_PAGE 6'h04
`define MPW_OFS_STATUS 6'h05

// Reset values of the software settings.
`define MPW_RST_RAM_SEL 3'h5
`define MPW_RST_EE_SEL 2'h2
`define MPW_RST_GBL_SEL 7'h00
`define MPW_RST_DP_BASE 8'h00
`define MPW_RST_DBG_PAGE 8'h00

// Debug page register: enable bit and page field.
`define MPW_DBG_EN_BIT 7
`define MPW_DBG_PAGE_MSB 6

// Fixed placement in the global space; no setting can move these.
`define MPW_RAM_BASE_HI 8'h1f
`define MPW_EE_BASE_HI 11'h13f
`define MPW_REG_PAGE 7'h00
`define MPW_FAR_PAGE 7'h7f

// Codes of the fixed blocks, also accepted by the window selects.
`define MPW_RAM_FIXED_HI 2'h3
`define MPW_EE_FIXED 2'h3

// Local map decode: upper address bits of each region.
`define MPW_LOC_REG_HI 5'h00
`define MPW_LOC_EE_WIN 6'h02
`define MPW_LOC_EE_FIX 6'h03
`define MPW_LOC_RAM_WIN 4'h1
`define MPW_LOC_RAM_FIX 3'h1

// External strobe width in clock cycles.
`define MPW_STROBE_CYCLES 2'h2

`endif

// *** sim/memory_page_windowing_bench.sv ***
/* Bench for mpw_core: reset values, then table of window settings and accesses,
   debug paging, refusals and a mid-run reset. Uses mpw_ext_mem as memory. */
`timescale 1ns/1ps
`default_nettype none
module memory_page_windowing_bench;
    typedef struct {logic [7:0] ofs; logic [7:0] val; logic [1:0] gd; logic [15:0] a;
        logic [22:0] exp;} mpw_row_t;
    logic mclk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, cpu_req_i, cpu_we_i;
    logic cpu_global_i, cpu_direct_i, cpu_ack_o, dbg_req_i, dbg_we_i, dbg_page_wr_i, dbg_ack_o;
    logic ext_data_oe_o, read_strobe_o, write_strobe_o;
    logic [7:0] avs_address_i, dbg_page_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd32;
    logic [3:0] avs_byteenable_i;
    logic [15:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, dbg_addr_i, dbg_wdata_i, dbg_rdata_o;
    logic [15:0] ext_data_o, ext_data_i, rd16;
    logic [22:0] ext_addr_o, seen;
    int n_mismatch, n_compared, cyc;
    logic [7:0] rst_v [5] = '{8'h05, 8'h02, 8'h00, 8'h00, 8'h00};
    mpw_row_t rt [9] = '{
        '{8'h00, 8'h00, 2'h0, 16'h1234, {8'h1f, 3'h0, 12'h234}},
        '{8'h04, 8'h00, 2'h0, 16'h0801, {11'h13f, 2'h0, 10'h001}},
        '{8'h04, 8'h03, 2'h0, 16'h0bff, {11'h13f, 2'h3, 10'h3ff}},
        '{8'h04, 8'h01, 2'h0, 16'h0c10, {11'h13f, 2'h3, 10'h010}},
        '{8'h00, 8'h07, 2'h0, 16'h3456, {8'h1f, 2'h3, 13'h1456}},
        '{8'h08, 8'h55, 2'h2, 16'h8000, {7'h55, 16'h8000}},
        '{8'h0c, 8'h21, 2'h1, 16'h00aa, {8'h1f, 2'h3, 13'h01aa}},
        '{8'h0c, 8'h21, 2'h3, 16'h00aa, {7'h55, 16'h00aa}},
        '{8'h08, 8'h7f, 2'h0, 16'h0123, {7'h00, 16'h0123}}};
    mpw_core mpw_core_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_global_i(cpu_global_i),
        .cpu_direct_i(cpu_direct_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o), .dbg_req_i(dbg_req_i),
        .dbg_we_i(dbg_we_i), .dbg_addr_i(dbg_addr_i), .dbg_wdata_i(dbg_wdata_i),
        .dbg_page_wr_i(dbg_page_wr_i), .dbg_page_i(dbg_page_i), .dbg_ack_o(dbg_ack_o),
        .dbg_rdata_o(dbg_rdata_o), .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o),
        .ext_data_oe_o(ext_data_oe_o), .ext_data_i(ext_data_i),
        .read_strobe_o(read_strobe_o), .write_strobe_o(write_strobe_o));
    mpw_ext_mem mpw_ext_mem_inst (.mclk_i(mclk_i), .ext_addr_i(ext_addr_o),
        .wr_data_i(ext_data_o), .data_oe_i(ext_data_oe_o), .read_strobe_i(read_strobe_o),
        .write_strobe_i(write_strobe_o), .rd_data_o(ext_data_i));
    always #2 mclk_i = ~mclk_i;
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic avs(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge mclk_i);
        {avs_address_i, avs_writedata_i, avs_read_i, avs_write_i} <= {ad, wd, ~wr, wr};
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rd32 = avs_readdata_o;
        {avs_read_i, avs_write_i} <= 2'h0;
    endtask
    task automatic acc(input logic d, we, input logic [1:0] gd, input logic [15:0] a, wd);
        @(posedge mclk_i);
        {cpu_we_i, dbg_we_i, cpu_global_i, cpu_direct_i} <= {we, we, gd};
        {cpu_addr_i, dbg_addr_i, cpu_wdata_i, dbg_wdata_i} <= {a, a, wd, wd};
        {cpu_req_i, dbg_req_i} <= {~d, d};
        do begin
            @(posedge mclk_i);
            if (read_strobe_o | write_strobe_o) seen = ext_addr_o;
        end while (cpu_ack_o !== 1'b1 && dbg_ack_o !== 1'b1);
        rd16 = d ? dbg_rdata_o : cpu_rdata_o;
        {cpu_req_i, dbg_req_i} <= 2'h0;
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        {mclk_i, arst_n_i, avs_read_i, avs_write_i, cpu_req_i, cpu_we_i, cpu_global_i} = '0;
        {cpu_direct_i, dbg_req_i, dbg_we_i, dbg_page_wr_i, dbg_page_i, avs_address_i} = '0;
        {avs_writedata_i, cpu_addr_i, cpu_wdata_i, dbg_addr_i, dbg_wdata_i} = '0;
        {avs_byteenable_i, n_mismatch, n_compared, cyc} = {4'hf, 96'h0};
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            avs(1'b0, {k[5:0], 2'h0}, 32'h0);
            chk("reset value", rd32, {24'h0, rst_v[k]});
        end
        for (int i = 0; i < 9; i++) begin
            avs(1'b1, rt[i].ofs, {24'h0, rt[i].val});
            acc(1'b0, 1'b1, rt[i].gd, rt[i].a, {8'h5a, i[7:0]});
            chk("window address", seen, rt[i].exp);
            acc(1'b0, 1'b0, rt[i].gd, rt[i].a, 16'h0);
            chk("read back", rd16, {8'h5a, i[7:0]});
        end
        $display("test table done");
        @(posedge mclk_i);
        {dbg_page_wr_i, dbg_page_i} <= {1'b1, 8'had};
        @(posedge mclk_i);
        dbg_page_wr_i <= 1'b0;
        acc(1'b1, 1'b1, 2'h0, 16'h1234, 16'hc3c3);
        chk("debug address", seen, {7'h2d, 16'h1234});
        acc(1'b1, 1'b0, 2'h0, 16'h1234, 16'h0);
        chk("debug read back", rd16, 16'hc3c3);
        avs(1'b0, 8'h14, 32'h0);
        chk("status after debug", rd32, 32'h022d1234);
        avs(1'b0, 8'h10, 32'h0);
        chk("debug page readable", rd32, 32'had);
        avs(1'b0, 8'h00, 32'h0);
        chk("user select kept", rd32, 32'h7);
        avs(1'b1, 8'hfc, 32'hff);
        avs(1'b0, 8'hfc, 32'h0);
        chk("unmapped", rd32, 32'h0);
        avs_byteenable_i <= 4'he;
        avs(1'b1, 8'h00, 32'h2);
        avs_byteenable_i <= 4'hf;
        avs(1'b0, 8'h00, 32'h0);
        chk("lane 0 off ignored", rd32, 32'h7);
        $display("test debug and refusals done");
        arst_n_i <= 1'b0;
        @(posedge mclk_i);
        chk("outputs in reset", {avs_waitrequest_o, read_strobe_o, write_strobe_o, dbg_ack_o},
            32'h8);
        arst_n_i <= 1'b1;
        avs(1'b0, 8'h00, 32'h0);
        chk("ram select after reset", rd32, 32'h5);
        avs(1'b0, 8'h10, 32'h0);
        chk("debug page after reset", rd32, 32'h0);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
`default_nettype wire

// *** sim/mpw_core_chk.sv ***
/* Checker for mpw_core: strobe shape, answer timing, fixed address map.
   Sees only the core's ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module mpw_core_chk #(
    parameter ADDR_W = 23
) (
    input wire mclk_i,
    input wire arst_n_i,
    input wire cpu_req_i,
    input wire cpu_global_i,
    input wire cpu_direct_i,
    input wire [15:0] cpu_addr_i,
    input wire cpu_ack_o,
    input wire dbg_req_i,
    input wire [15:0] dbg_addr_i,
    input wire dbg_ack_o,
    input wire dbg_page_wr_i,
    input wire [7:0] dbg_page_i,
    input wire [ADDR_W-1:0] ext_addr_o,
    input wire ext_data_oe_o,
    input wire read_strobe_o,
    input wire write_strobe_o
);
    logic dbg_own_reg;
    logic cpu_own_reg;
    logic [7:0] pg_reg;
    wire cpu_loc = cpu_own_reg & ~cpu_global_i & ~cpu_direct_i;
    // Owner is decided at the taking edge, the same edge that raises the strobe.
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dbg_own_reg <= 1'b0;
            cpu_own_reg <= 1'b0;
            pg_reg <= 8'h00;
        end else begin
            dbg_own_reg <= dbg_req_i;
            cpu_own_reg <= cpu_req_i & ~dbg_req_i;
            if (dbg_page_wr_i) pg_reg <= dbg_page_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_start;
        $rose(read_strobe_o) || $rose(write_strobe_o);
    endsequence
    sequence s_done;
        ##2 (cpu_ack_o || dbg_ack_o);
    endsequence
    chk_strobe_excl: assert property (!(read_strobe_o && write_strobe_o))
        else $error("both strobes high");
    chk_read_len: assert property ($rose(read_strobe_o) |-> read_strobe_o[*2] ##1 !read_strobe_o)
        else $error("read strobe length");
    chk_write_drive: assert property ($rose(write_strobe_o) |->
        (write_strobe_o && ext_data_oe_o)[*2] ##1 !write_strobe_o) else $error("write strobe");
    chk_ack_timing: assert property (s_start |-> s_done)
        else $error("ack late");
    chk_reg_fixed: assert property (s_start ##0 (cpu_loc && cpu_addr_i[15:11] == 5'h00) |->
        ext_addr_o == {7'h00, cpu_addr_i}) else $error("register area moved");
    chk_ee_fixed: assert property (s_start ##0 (cpu_loc && cpu_addr_i[15:10] == 6'h03) |->
        ext_addr_o == {11'h13f, 2'h3, cpu_addr_i[9:0]}) else $error("fixed eeprom moved");
    chk_ram_fixed: assert property (s_start ##0 (cpu_loc && cpu_addr_i[15:13] == 3'h1) |->
        ext_addr_o == {8'h1f, 2'h3, cpu_addr_i[12:0]}) else $error("fixed ram moved");
    chk_dbg_page: assert property (s_start ##0 (dbg_own_reg && pg_reg[7]) |->
        ext_addr_o == {pg_reg[6:0], dbg_addr_i}) else $error("debug page address");
endmodule
bind mpw_core mpw_core_chk #(.ADDR_W(ADDR_W)) mpw_core_chk_inst (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .cpu_req_i(cpu_req_i), .cpu_global_i(cpu_global_i),
    .cpu_direct_i(cpu_direct_i), .cpu_addr_i(cpu_addr_i), .cpu_ack_o(cpu_ack_o),
    .dbg_req_i(dbg_req_i), .dbg_addr_i(dbg_addr_i), .dbg_ack_o(dbg_ack_o),
    .dbg_page_wr_i(dbg_page_wr_i), .dbg_page_i(dbg_page_i), .ext_addr_o(ext_addr_o),
    .ext_data_oe_o(ext_data_oe_o), .read_strobe_o(read_strobe_o),
    .write_strobe_o(write_strobe_o));
`default_nettype wire

// *** sim/mpw_ext_mem.sv ***
/* External memory behind the core's bus. Assumes one strobe at a time. */
`timescale 1ns/1ps
`default_nettype none
module mpw_ext_mem (
    input wire logic mclk_i,
    input wire logic [22:0] ext_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic data_oe_i,
    input wire logic read_strobe_i,
    input wire logic write_strobe_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem [256];
    logic [15:0] last_reg = 16'h0;
    // Low byte indexes storage; the bench reads each word back at once.
    always @(posedge mclk_i) begin
        if (write_strobe_i && data_oe_i) mem[ext_addr_i[7:0]] <= wr_data_i;
        last_reg <= rd_data_o;
    end
    // Idle lines toggle, so a sample one cycle late sees the inverted word, not the old one.
    assign rd_data_o = read_strobe_i ? mem[ext_addr_i[7:0]] : ~last_reg;
endmodule
`default_nettype wire
